// ==== rtl/crb_cfg_check.sv ====
`timescale 1ns/1ps
`default_nettype none

module crb_cfg_check
    import crb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire crb_cfg_s cfg,
    output logic cfgError
);

    // ****************************************************************
    // Mode legality
    // ****************************************************************
    logic wideA;
    logic wideB;
    logic next_cfgError;

    always_comb begin
        wideA = (cfg.shapeA == SH_128X32) || (cfg.shapeA == SH_128X36);
        wideB = (cfg.shapeB == SH_128X32) || (cfg.shapeB == SH_128X36);
        next_cfgError = 1'b0;
        if (cfg.clkMode == CM_INDEP && cfg.portMode != PM_TRUE) begin
            next_cfgError = 1'b1;
        end
        if (cfg.clkMode == CM_RDWR && cfg.portMode != PM_SIMPLE) begin
            next_cfgError = 1'b1;
        end
        if (cfg.portMode == PM_TRUE && (wideA || wideB)) begin
            next_cfgError = 1'b1;
        end
        if (cfg.portMode == PM_PACKED && cfg.clkMode != CM_SINGLE) begin
            next_cfgError = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfgError <= 1'b0;
        end else begin
            cfgError <= next_cfgError;
        end
    end

endmodule : crb_cfg_check

`default_nettype wire

// ==== rtl/crb_out_stage.sv ====
`timescale 1ns/1ps
`default_nettype none

module crb_out_stage
    import crb_pkg::*;
#(
    parameter int W = CRB_DATA_W
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rawLoad,
    input wire logic [W-1:0] rawData,
    input wire logic outLoad,
    input wire logic clr,
    input wire logic bypass,
    output logic [W-1:0] dout
);

    // ****************************************************************
    // Read latch and output register
    // ****************************************************************
    logic [W-1:0] rawReg;

    // The read latch is not an output register, so a clear leaves it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rawReg <= W'(CRB_DOUT_RESET);
        end else if (rawLoad) begin
            rawReg <= rawData;
        end
    end

    // Bypass loads the pin flop straight from the array, saving a cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dout <= W'(CRB_DOUT_RESET);
        end else if (clr) begin
            dout <= W'(CRB_DOUT_RESET);
        end else if (bypass && rawLoad) begin
            dout <= rawData;
        end else if (!bypass && outLoad) begin
            dout <= rawReg;
        end
    end

endmodule : crb_out_stage

`default_nettype wire

// ==== rtl/crb_pkg.sv ====
package crb_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int CRB_BITS = 4608;
    localparam int CRB_WORD_W = 36;
    localparam int CRB_WORDS = CRB_BITS / CRB_WORD_W;
    localparam int CRB_WORD_IDX_W = 7;
    localparam int CRB_ADDR_W = 12;
    localparam int CRB_DATA_W = 36;
    localparam int CRB_BE_W = 4;
    localparam int CRB_BIT_IDX_W = 13;
    localparam logic [5:0] CRB_LANE_W = 6'h09;
    localparam logic [5:0] CRB_BYTE_W = 6'h08;
    localparam logic [5:0] CRB_PARITY_WORD_W = 6'h24;
    localparam logic [CRB_DATA_W-1:0] CRB_DOUT_RESET = 36'h0_0000_0000;

    // ****************************************************************
    // Modes and shapes
    // ****************************************************************
    typedef enum logic [2:0] {
        PM_SINGLE,
        PM_SIMPLE,
        PM_TRUE,
        PM_ROM,
        PM_SHIFT,
        PM_PACKED
    } crb_port_mode_e;

    typedef enum logic [1:0] {
        CM_INDEP,
        CM_INOUT,
        CM_RDWR,
        CM_SINGLE
    } crb_clk_mode_e;

    typedef enum logic [3:0] {
        SH_4KX1,
        SH_2KX2,
        SH_1KX4,
        SH_512X8,
        SH_512X9,
        SH_256X16,
        SH_256X18,
        SH_128X32,
        SH_128X36
    } crb_shape_e;

    typedef struct packed {
        crb_port_mode_e portMode;
        crb_clk_mode_e clkMode;
        crb_shape_e shapeA;
        crb_shape_e shapeB;
        logic outRegA;
        logic outRegB;
    } crb_cfg_s;

    typedef struct packed {
        logic [CRB_ADDR_W-1:0] addr;
        logic [CRB_DATA_W-1:0] din;
        logic [CRB_BE_W-1:0] be;
        logic we;
        logic addrHold;
    } crb_req_s;

    // ****************************************************************
    // Shape arithmetic
    // ****************************************************************
    function automatic logic [5:0] shapeWidth(input crb_shape_e s);
        unique case (s)
            SH_4KX1: shapeWidth = 6'h01;
            SH_2KX2: shapeWidth = 6'h02;
            SH_1KX4: shapeWidth = 6'h04;
            SH_512X8: shapeWidth = 6'h08;
            SH_512X9: shapeWidth = 6'h09;
            SH_256X16: shapeWidth = 6'h10;
            SH_256X18: shapeWidth = 6'h12;
            SH_128X32: shapeWidth = 6'h20;
            SH_128X36: shapeWidth = 6'h24;
        endcase
    endfunction : shapeWidth

    function automatic logic shapeParity(input crb_shape_e s);
        shapeParity = (s == SH_512X9) || (s == SH_256X18) ||
            (s == SH_128X36);
    endfunction : shapeParity

    // Plain shapes skip the parity bit of each 9-bit lane
    function automatic logic [5:0] physBit(input logic parity,
                                           input logic [5:0] p);
        if (parity) begin
            physBit = p;
        end else begin
            physBit = 6'((p[5:3] * CRB_LANE_W) + {3'h0, p[2:0]});
        end
    endfunction : physBit

    function automatic logic [CRB_BIT_IDX_W-1:0] bitIndex(
        input crb_shape_e s, input logic [CRB_ADDR_W-1:0] a);
        bitIndex = CRB_BIT_IDX_W'(a) * CRB_BIT_IDX_W'(shapeWidth(s));
    endfunction : bitIndex

    function automatic logic [CRB_WORD_IDX_W-1:0] wordOf(
        input crb_shape_e s, input logic [CRB_ADDR_W-1:0] a);
        logic [CRB_BIT_IDX_W-1:0] idx;
        idx = bitIndex(s, a);
        if (shapeParity(s)) begin
            wordOf = CRB_WORD_IDX_W'(idx / CRB_PARITY_WORD_W);
        end else begin
            wordOf = CRB_WORD_IDX_W'(idx >> 5);
        end
    endfunction : wordOf

    function automatic logic [5:0] offOf(input crb_shape_e s,
                                         input logic [CRB_ADDR_W-1:0] a);
        logic [CRB_BIT_IDX_W-1:0] idx;
        idx = bitIndex(s, a);
        if (shapeParity(s)) begin
            offOf = 6'(idx % CRB_PARITY_WORD_W);
        end else begin
            offOf = {1'b0, idx[4:0]};
        end
    endfunction : offOf

endpackage : crb_pkg

// ==== rtl/crb_ram.sv ====
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Array holds 4608 bits including parity
// - Shapes 4Kx1 to 128x36; wide ones not true-dual
// - Ninth bit per byte stored; parity logic external
// - Byte enables for every write width
// - Disabled bytes keep their old contents
// - Packed: two single-port halves, single clock only
// - Address hold keeps the previous registered address
// - Contents preloaded from image; ROM never written
// - Same-port read during write returns new data
// - Mixed-port read during write returns old data
// - Simple dual: one write, one read port
// - True dual: both ports read or write
// - Shift use: write falling edge, read rising
// - Independent: port A on ce0, port B on ce1
// - In/out: inputs on ce0, outputs on ce1
// - Read/write: write side ce0, read side ce1
// - Single: ce0 drives all; no output clear
// - Independent and read/write clock modes allowed only with matching port mode
// - Input registers fixed; output registers bypassable
module crb_ram
    import crb_pkg::*;
#(
    parameter logic [CRB_BITS-1:0] INIT_IMAGE = '0
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire crb_cfg_s cfg,
    input wire logic ce0,
    input wire logic ce1,
    input wire logic outClr,
    input wire crb_req_s reqA,
    input wire crb_req_s reqB,
    output logic [CRB_DATA_W-1:0] doutA,
    output logic [CRB_DATA_W-1:0] doutB,
    output logic cfgError
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    typedef logic [CRB_WORD_W-1:0] crb_mem_t [CRB_WORDS];

    // The image is the only source of contents; the array never resets
    function automatic crb_mem_t initMem();
        crb_mem_t m;
        for (int i = 0; i < CRB_WORDS; i++) begin
            m[i] = INIT_IMAGE[i*CRB_WORD_W +: CRB_WORD_W];
        end
        initMem = m;
    endfunction : initMem

    crb_mem_t mem = initMem();

    function automatic logic [CRB_WORD_W-1:0] merge(
        input logic [CRB_WORD_W-1:0] old,
        input logic [CRB_WORD_W-1:0] mask,
        input logic [CRB_WORD_W-1:0] data);
        merge = (old & ~mask) | (data & mask);
    endfunction : merge

    // Builds lane mask and data placed at the physical bit positions
    function automatic logic [2*CRB_WORD_W-1:0] place(
        input crb_shape_e s, input logic [5:0] off,
        input logic [CRB_DATA_W-1:0] din, input logic [CRB_BE_W-1:0] be);
        logic [CRB_WORD_W-1:0] m;
        logic [CRB_WORD_W-1:0] d;
        logic [5:0] pb;
        logic [5:0] lane;
        logic par;
        m = '0;
        d = '0;
        pb = '0;
        lane = '0;
        par = shapeParity(s);
        for (int j = 0; j < CRB_DATA_W; j++) begin
            if (6'(j) < shapeWidth(s)) begin
                pb = physBit(par, 6'(off + 6'(j)));
                lane = par ? 6'(6'(j) / CRB_LANE_W) : 6'(6'(j) / CRB_BYTE_W);
                d[pb] = din[j];
                if (shapeWidth(s) < CRB_BYTE_W) begin
                    m[pb] = be[0];
                end else begin
                    m[pb] = be[lane[1:0]];
                end
            end
        end
        place = {m, d};
    endfunction : place

    function automatic logic [CRB_DATA_W-1:0] extract(
        input crb_shape_e s, input logic [5:0] off,
        input logic [CRB_WORD_W-1:0] w);
        logic [CRB_DATA_W-1:0] r;
        r = '0;
        for (int j = 0; j < CRB_DATA_W; j++) begin
            if (6'(j) < shapeWidth(s)) begin
                r[j] = w[physBit(shapeParity(s), 6'(off + 6'(j)))];
            end
        end
        extract = r;
    endfunction : extract

    // ****************************************************************
    // Configuration check
    // ****************************************************************
    crb_cfg_check u_check (
        .clk(clk),
        .rst_b(rst_b),
        .cfg(cfg),
        .cfgError(cfgError)
    );

    // ****************************************************************
    // Clock-mode enables
    // ****************************************************************
    logic inEnA;
    logic inEnB;
    logic outEnA;
    logic outEnB;
    logic portBUsed;
    logic portBWrites;
    logic portAWrites;
    logic clrEn;

    // One fabric clock; the mode's clocks arrive as ce0 and ce1 ticks
    always_comb begin
        inEnA = ce0;
        unique case (cfg.clkMode)
            CM_INDEP: begin
                inEnB = ce1;
                outEnA = ce0;
                outEnB = ce1;
            end
            CM_INOUT: begin
                inEnB = ce0;
                outEnA = ce1;
                outEnB = ce1;
            end
            CM_RDWR: begin
                inEnB = ce1;
                outEnA = ce1;
                outEnB = ce1;
            end
            CM_SINGLE: begin
                inEnB = ce0;
                outEnA = ce0;
                outEnB = ce0;
            end
        endcase
        portBUsed = (cfg.portMode == PM_SIMPLE) ||
            (cfg.portMode == PM_TRUE) || (cfg.portMode == PM_PACKED);
        portBWrites = (cfg.portMode == PM_TRUE) ||
            (cfg.portMode == PM_PACKED);
        portAWrites = (cfg.portMode != PM_ROM) && !cfgError;
        clrEn = outClr && (cfg.clkMode != CM_SINGLE);
    end

    // ****************************************************************
    // Input registers
    // ****************************************************************
    crb_req_s regA;
    crb_req_s regB;
    logic tookA;
    logic tookB;

    always_ff @(posedge clk) begin
        if (inEnA) begin
            if (!reqA.addrHold) begin
                regA.addr <= reqA.addr;
            end
            regA.din <= reqA.din;
            regA.be <= reqA.be;
        end
        if (inEnB) begin
            if (!reqB.addrHold) begin
                regB.addr <= reqB.addr;
            end
            regB.din <= reqB.din;
            regB.be <= reqB.be;
        end
        // Strobes reset so a stray write cannot follow reset release
        if (!rst_b) begin
            regA.we <= 1'b0;
            regB.we <= 1'b0;
            regA.addrHold <= 1'b0;
            regB.addrHold <= 1'b0;
            tookA <= 1'b0;
            tookB <= 1'b0;
        end else begin
            regA.we <= inEnA && reqA.we;
            regB.we <= inEnB && reqB.we;
            regA.addrHold <= reqA.addrHold;
            regB.addrHold <= reqB.addrHold;
            tookA <= inEnA;
            tookB <= inEnB && portBUsed;
        end
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic [CRB_WORD_IDX_W-1:0] wordA;
    logic [CRB_WORD_IDX_W-1:0] wordB;
    logic [5:0] offA;
    logic [5:0] offB;
    logic weEffA;
    logic weEffB;
    logic sameWord;

    always_comb begin
        wordA = wordOf(cfg.shapeA, regA.addr);
        wordB = wordOf(cfg.shapeB, regB.addr);
        offA = offOf(cfg.shapeA, regA.addr);
        offB = offOf(cfg.shapeB, regB.addr);
        if (cfg.portMode == PM_PACKED) begin
            wordA[CRB_WORD_IDX_W-1] = 1'b0;
            wordB[CRB_WORD_IDX_W-1] = 1'b1;
        end
        weEffA = regA.we && portAWrites;
        weEffB = regB.we && portBWrites && !cfgError;
        sameWord = (wordA == wordB);
    end

    // ****************************************************************
    // Array write on the falling edge
    // ****************************************************************
    logic [2*CRB_WORD_W-1:0] plA;
    logic [2*CRB_WORD_W-1:0] plB;
    logic [CRB_WORD_W-1:0] oldA;
    logic [CRB_WORD_W-1:0] oldB;

    always_comb begin
        plA = place(cfg.shapeA, offA, regA.din, regA.be);
        plB = place(cfg.shapeB, offB, regB.din, regB.be);
    end

    // Half a cycle after the input edge, so the next rising edge reads it
    always_ff @(negedge clk) begin
        oldA <= mem[wordA];
        oldB <= mem[wordB];
        if (weEffA) begin
            mem[wordA] <= merge(mem[wordA], plA[2*CRB_WORD_W-1:CRB_WORD_W],
                plA[CRB_WORD_W-1:0]);
        end
        if (weEffB) begin
            mem[wordB] <= merge((weEffA && sameWord) ?
                merge(mem[wordA], plA[2*CRB_WORD_W-1:CRB_WORD_W],
                plA[CRB_WORD_W-1:0]) : mem[wordB],
                plB[2*CRB_WORD_W-1:CRB_WORD_W], plB[CRB_WORD_W-1:0]);
        end
    end

    // ****************************************************************
    // Read on the rising edge
    // ****************************************************************
    logic [CRB_WORD_W-1:0] srcA;
    logic [CRB_WORD_W-1:0] srcB;
    logic [CRB_DATA_W-1:0] rdA;
    logic [CRB_DATA_W-1:0] rdB;

    // Own write shows new data; only the other port's write is undone
    always_comb begin
        srcA = mem[wordA];
        srcB = mem[wordB];
        if (weEffB && sameWord && !weEffA) begin
            srcA = oldB;
        end
        if (weEffA && sameWord && !weEffB) begin
            srcB = oldA;
        end
        rdA = extract(cfg.shapeA, offA, srcA);
        rdB = extract(cfg.shapeB, offB, srcB);
    end

    // ****************************************************************
    // Output stages
    // ****************************************************************
    crb_out_stage #(.W(CRB_DATA_W)) u_outA (
        .clk(clk),
        .rst_b(rst_b),
        .rawLoad(tookA),
        .rawData(rdA),
        .outLoad(outEnA),
        .clr(clrEn),
        .bypass(!cfg.outRegA),
        .dout(doutA)
    );

    crb_out_stage #(.W(CRB_DATA_W)) u_outB (
        .clk(clk),
        .rst_b(rst_b),
        .rawLoad(tookB),
        .rawData(rdB),
        .outLoad(outEnB),
        .clr(clrEn),
        .bypass(!cfg.outRegB),
        .dout(doutB)
    );

endmodule : crb_ram

`default_nettype wire

// ==== test/crb_fabric_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module crb_fabric_model
    import crb_pkg::*;
(
    input wire logic clk,
    output var crb_req_s reqA,
    output var crb_req_s reqB,
    output logic ce0,
    output logic ce1
);
    initial begin
        reqA = '0;
        reqB = '0;
        ce0 = 1'b0;
        ce1 = 1'b0;
    end

    task automatic issue(input crb_req_s a, input crb_req_s b,
                         input logic e0, input logic e1);
        @(posedge clk);
        reqA <= a;
        reqB <= b;
        ce0 <= e0;
        ce1 <= e1;
    endtask : issue

    // Released lines flip so stale data cannot pass for an answer
    task automatic idle();
        @(posedge clk);
        reqA <= '{~reqA.addr, ~reqA.din, 4'h0, 1'b0, 1'b0};
        reqB <= '{~reqB.addr, ~reqB.din, 4'h0, 1'b0, 1'b0};
        ce0 <= 1'b0;
        ce1 <= 1'b0;
    endtask : idle
endmodule : crb_fabric_model

`default_nettype wire

// ==== test/crb_ram_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module crb_ram_assertions
    import crb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire crb_cfg_s cfg,
    input wire logic ce0,
    input wire logic ce1,
    input wire logic outClr,
    input wire crb_req_s reqA,
    input wire crb_req_s reqB,
    input wire logic [CRB_DATA_W-1:0] doutA,
    input wire logic [CRB_DATA_W-1:0] doutB,
    input wire logic cfgError
);
    // ************************************************************
    // Port properties
    // ************************************************************
    // Reset itself is the cause here, so no disable
    property p_rstOut;
        @(posedge clk) !rst_b |=> doutA == CRB_DOUT_RESET &&
            doutB == CRB_DOUT_RESET && !cfgError;
    endproperty
    a_rstOut: assert property (p_rstOut)
        else $error("outputs not cleared by reset");

    property p_sameRw;
        @(posedge clk) disable iff (!rst_b)
        ce0 && reqA.we && reqA.be == 4'hF && !reqA.addrHold &&
        !cfgError && cfg.clkMode == CM_SINGLE && !cfg.outRegA &&
        cfg.shapeA == SH_128X36 &&
        cfg.portMode inside {PM_SINGLE, PM_SIMPLE}
        |-> ##2 doutA == $past(reqA.din, 2);
    endproperty
    a_sameRw: assert property (p_sameRw)
        else $error("same-port write did not show new data");

    property p_cfgTrue;
        @(posedge clk) disable iff (!rst_b)
        cfg.portMode == PM_TRUE &&
        cfg.shapeA inside {SH_128X32, SH_128X36} |=> cfgError;
    endproperty
    a_cfgTrue: assert property (p_cfgTrue)
        else $error("wide shape accepted in true dual-port");

    property p_cfgIndep;
        @(posedge clk) disable iff (!rst_b)
        cfg.clkMode == CM_INDEP &&
        cfg.portMode inside {PM_SINGLE, PM_SIMPLE} |=> cfgError;
    endproperty
    a_cfgIndep: assert property (p_cfgIndep)
        else $error("independent clocking accepted");

    property p_cfgRdwr;
        @(posedge clk) disable iff (!rst_b)
        cfg.clkMode == CM_RDWR &&
        cfg.portMode inside {PM_SINGLE, PM_TRUE} |=> cfgError;
    endproperty
    a_cfgRdwr: assert property (p_cfgRdwr)
        else $error("read/write clocking accepted");

    property p_cfgPacked;
        @(posedge clk) disable iff (!rst_b)
        cfg.portMode == PM_PACKED && cfg.clkMode != CM_SINGLE
        |=> cfgError;
    endproperty
    a_cfgPacked: assert property (p_cfgPacked)
        else $error("packed mode accepted without single clock");

    property p_clr;
        @(posedge clk) disable iff (!rst_b)
        cfg.outRegA && cfg.clkMode == CM_INOUT && outClr && !ce1
        |=> doutA == CRB_DOUT_RESET;
    endproperty
    a_clr: assert property (p_clr)
        else $error("output register not cleared");

    property p_noClrSingle;
        @(posedge clk) disable iff (!rst_b)
        cfg.outRegA && cfg.clkMode == CM_SINGLE && outClr && !ce0
        |=> $stable(doutA);
    endproperty
    a_noClrSingle: assert property (p_noClrSingle)
        else $error("clear acted in single clock mode");

    property p_holdInout;
        @(posedge clk) disable iff (!rst_b)
        cfg.outRegA && cfg.clkMode == CM_INOUT && !ce1 && !outClr
        |=> $stable(doutA);
    endproperty
    a_holdInout: assert property (p_holdInout)
        else $error("output register moved without output clock");

    c_mixed: cover property (@(posedge clk) disable iff (!rst_b)
        ce0 && reqA.we && !reqB.we && reqA.addr == reqB.addr);
    c_hold: cover property (@(posedge clk) disable iff (!rst_b)
        ce0 && reqA.addrHold);
    c_clr: cover property (@(posedge clk) disable iff (!rst_b)
        outClr && cfg.outRegA);
endmodule : crb_ram_assertions

bind crb_ram crb_ram_assertions crb_ram_assertions_i (
    .clk(clk), .rst_b(rst_b), .cfg(cfg), .ce0(ce0), .ce1(ce1),
    .outClr(outClr), .reqA(reqA), .reqB(reqB), .doutA(doutA),
    .doutB(doutB), .cfgError(cfgError));

`default_nettype wire

// ==== test/test_configurable_block_ram.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_configurable_block_ram
    import crb_pkg::*;
;
    localparam logic [CRB_BITS-1:0] IMG =
        {4536'h0, 36'h5_A5A5_A5A5, 36'h9_8765_4321};
    localparam logic [35:0] PAR = 36'h8_0402_0100;
    localparam logic [35:0] NEW = 36'h1_2345_6789;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic outClr = 1'b0;
    crb_cfg_s cfg = '{PM_SINGLE, CM_SINGLE, SH_128X36, SH_128X36, 1'b0, 1'b0};
    crb_req_s reqA;
    crb_req_s reqB;
    logic ce0;
    logic ce1;
    logic cfgError;
    logic [CRB_DATA_W-1:0] doutA;
    logic [CRB_DATA_W-1:0] doutB;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    crb_ram #(.INIT_IMAGE(IMG)) crb_ram_i (.clk(clk), .rst_b(rst_b),
        .cfg(cfg), .ce0(ce0), .ce1(ce1), .outClr(outClr), .reqA(reqA),
        .reqB(reqB), .doutA(doutA), .doutB(doutB), .cfgError(cfgError));
    crb_fabric_model crb_fabric_model_i (.clk(clk), .reqA(reqA),
        .reqB(reqB), .ce0(ce0), .ce1(ce1));

    initial begin
        forever #25 clk = ~clk;
    end

    // A hang costs at most this many cycles, far above the plan
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            conclude();
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [35:0] exp,
                       input logic [35:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic crb_req_s wr(input logic [11:0] a,
        input logic [35:0] d, input logic [3:0] be);
        wr = '{a, d, be, 1'b1, 1'b0};
    endfunction : wr

    function automatic crb_req_s rd(input logic [11:0] a);
        rd = '{a, 36'h0, 4'h0, 1'b0, 1'b0};
    endfunction : rd

    task automatic op(input crb_req_s a, input crb_req_s b,
                      input logic e1, input int waits);
        crb_fabric_model_i.issue(a, b, 1'b1, e1);
        repeat (waits) @(posedge clk);
        #1;
    endtask : op

    task automatic setCfg(input crb_port_mode_e pm,
        input crb_clk_mode_e cm, input crb_shape_e sh, input logic ra);
        crb_fabric_model_i.idle();
        cfg <= '{pm, cm, sh, sh, ra, 1'b0};
        repeat (2) @(posedge clk);
        #1;
    endtask : setCfg

    task automatic pulseClr();
        crb_fabric_model_i.idle();
        outClr <= 1'b1;
        @(posedge clk);
        outClr <= 1'b0;
        #1;
    endtask : pulseClr

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_write();
        for (int i = 0; i < 2; i++) begin
            op(rd(12'(i)), rd(12'h000), 1'b0, 2);
            chk("preload", IMG[i*36 +: 36], doutA);
        end
        op(wr(12'h005, PAR, 4'hF), rd(12'h000), 1'b0, 2);
        chk("same-port", PAR, doutA);
        op(wr(12'h006, 36'h0, 4'hF), rd(12'h000), 1'b0, 1);
        op(wr(12'h006, 36'hF_FFFF_FFFF, 4'h5), rd(12'h000), 1'b0, 1);
        op(rd(12'h006), rd(12'h000), 1'b0, 2);
        chk("masked", 36'h0_07FC_01FF, doutA);
        op(rd(12'h005), rd(12'h000), 1'b0, 2);
        chk("parity", PAR, doutA);
    endtask : t_write

    task automatic t_mixed();
        setCfg(PM_SIMPLE, CM_SINGLE, SH_128X36, 1'b0);
        op(wr(12'h005, NEW, 4'hF), rd(12'h005), 1'b0, 2);
        chk("mixed", PAR, doutB);
        op(rd(12'h000), rd(12'h005), 1'b0, 2);
        chk("read port", NEW, doutB);
        setCfg(PM_SINGLE, CM_SINGLE, SH_128X36, 1'b0);
        op(wr(12'h007, NEW, 4'hF), rd(12'h000), 1'b0, 1);
        op('{12'h000, 36'h0, 4'h0, 1'b0, 1'b1}, rd(12'h000), 1'b0, 2);
        chk("addr hold", NEW, doutA);
        setCfg(PM_ROM, CM_SINGLE, SH_128X36, 1'b0);
        op(wr(12'h001, 36'h0, 4'hF), rd(12'h000), 1'b0, 1);
        op(rd(12'h001), rd(12'h000), 1'b0, 2);
        chk("rom", IMG[71:36], doutA);
    endtask : t_mixed

    task automatic t_outreg();
        setCfg(PM_SINGLE, CM_INOUT, SH_128X36, 1'b1);
        op(rd(12'h007), rd(12'h000), 1'b1, 3);
        chk("out reg", NEW, doutA);
        pulseClr();
        chk("clear", 36'h0, doutA);
        op(rd(12'h007), rd(12'h000), 1'b0, 3);
        chk("no out clock", 36'h0, doutA);
        setCfg(PM_SINGLE, CM_SINGLE, SH_128X36, 1'b1);
        op(rd(12'h007), rd(12'h000), 1'b0, 3);
        chk("single out", NEW, doutA);
        pulseClr();
        chk("no clear", NEW, doutA);
    endtask : t_outreg

    task automatic t_cfg();
        crb_port_mode_e pm[5] = '{PM_TRUE, PM_TRUE, PM_SIMPLE, PM_PACKED,
            PM_TRUE};
        crb_clk_mode_e cm[5] = '{CM_SINGLE, CM_RDWR, CM_INDEP, CM_INOUT,
            CM_INDEP};
        logic ex[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++) begin
            setCfg(pm[i], cm[i], (i == 0) ? SH_128X36 : SH_256X18, 1'b0);
            chk("cfgError", {35'h0, ex[i]}, {35'h0, cfgError});
        end
        op(rd(12'h000), wr(12'h003, 36'h0_0002_5A5A, 4'hF), 1'b1, 1);
        op(rd(12'h003), rd(12'h000), 1'b1, 2);
        chk("true dual", 36'h0_0002_5A5A, doutA);
        op(rd(12'h003), wr(12'h003, 36'h0, 4'hF), 1'b0, 1);
        op(rd(12'h003), rd(12'h000), 1'b1, 2);
        chk("indep", 36'h0_0002_5A5A, doutA);
        setCfg(PM_PACKED, CM_SINGLE, SH_128X36, 1'b0);
        op(wr(12'h000, NEW, 4'hF), wr(12'h000, PAR, 4'hF), 1'b0, 2);
        chk("packed A", NEW, doutA);
        chk("packed B", PAR, doutB);
    endtask : t_cfg

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("doutA", 36'h0, doutA);
        chk("doutB", 36'h0, doutB);
        chk("cfgError", 36'h0, {35'h0, cfgError});
        t_write();
        t_mixed();
        t_outreg();
        t_cfg();
        conclude();
    end
endmodule : test_configurable_block_ram

`default_nettype wire
